// file: siowa_top.sv
// slave i/o word allocator: word area, node flags and register slave
//
// Implementation choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
module siowa_top #(
    parameter int NARROW_SLOTS = siowa_pkg::SIOWA_NARROW_SLOTS
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire siowa_pkg::siowa_avm_req_t avm,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire siowa_pkg::siowa_link_req_t link_req,
    output siowa_pkg::siowa_link_rsp_t link_rsp,
    output logic link_participation_lamp
);
    // ==========================================================
    // elaboration check
    if (NARROW_SLOTS < 1 ||
        NARROW_SLOTS > siowa_pkg::SIOWA_SLOTS) begin : g_chk
        $error("narrow slot count out of range");
    end

    siowa_pkg::siowa_state_t s;
    siowa_pkg::siowa_state_t next_s;

    logic [15:0][3:0] base;
    logic [15:0][15:0] slots;
    logic [15:0][63:0] dmask;
    logic [15:0] legal;
    logic [15:0] acc;
    logic [15:0] rej;
    logic [15:0] claim_o;
    logic [15:0] claim_i;
    logic clash;

    logic rd;
    logic wr;
    logic restart;
    logic [7:0] a;
    logic [2:0] oidx;
    logic [2:0] iidx;
    logic [3:0] cidx;
    logic [31:0] cur;
    logic [31:0] merged;
    logic fire;
    logic acc_fire;
    siowa_pkg::siowa_cfg_t fc;
    logic [6:0] sh;
    logic [63:0] f_mask;
    logic [15:0] fo_slots;
    logic [15:0] fi_slots;
    logic [127:0] wmask;
    logic [127:0] wdat;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // ==========================================================
    // span decoders
    for (genvar g = 0; g < siowa_pkg::SIOWA_SLOTS; g++) begin : g_span
        siowa_span #(
            .NARROW_SLOTS(NARROW_SLOTS)
        ) u_span (
            .cfg(s.cfg[g]),
            .wide(s.wide),
            .base(base[g]),
            .slots(slots[g]),
            .dmask(dmask[g]),
            .legal(legal[g])
        );
    end

    // ==========================================================
    // acceptance
    // lower entries win; a later clashing entry is refused whole
    always_comb begin
        claim_o = 16'h0000;
        claim_i = 16'h0000;
        clash = 1'b0;
        for (int i = 0; i < siowa_pkg::SIOWA_SLOTS; i++) begin
            clash = (s.cfg[i].out_dir && (|(claim_o & slots[i]))) ||
                    (s.cfg[i].in_dir && (|(claim_i & slots[i])));
            acc[i] = legal[i] & ~clash;
            if (acc[i] && s.cfg[i].out_dir) begin
                claim_o = claim_o | slots[i];
            end
            if (acc[i] && s.cfg[i].in_dir) begin
                claim_i = claim_i | slots[i];
            end
            rej[i] = s.cfg[i].en & ~acc[i];
        end
    end

    // ==========================================================
    // next state
    always_comb begin
        next_s = s;
        next_s.ack = 1'b0;
        next_s.rsp = '0;
        restart = 1'b0;
        rd = avm.read & ~s.ack;
        wr = avm.write & ~s.ack;
        a = avm.address;
        oidx = 3'((a - siowa_pkg::SIOWA_OUT_BASE) >> 2);
        iidx = 3'((a - siowa_pkg::SIOWA_IN_BASE) >> 2);
        cidx = 4'((a - siowa_pkg::SIOWA_CFG_BASE) >> 2);
        cur = siowa_pkg::SIOWA_UNMAPPED_RD;
        if (a == siowa_pkg::SIOWA_ADDR_CTRL) begin
            cur[siowa_pkg::SIOWA_CTRL_RUN] = s.run;
            cur[siowa_pkg::SIOWA_CTRL_WIDE] = s.wide;
        end else if (a == siowa_pkg::SIOWA_ADDR_STATUS) begin
            cur = {rej, 15'h0, s.lamp};
        end else if (a == siowa_pkg::SIOWA_ADDR_ACTIVE) begin
            cur = {s.act_in, s.act_out};
        end else if (a == siowa_pkg::SIOWA_ADDR_ERROR) begin
            cur = {s.err_in, s.err_out};
        end else if (a >= siowa_pkg::SIOWA_OUT_BASE && a <
                     siowa_pkg::SIOWA_OUT_BASE + siowa_pkg::SIOWA_AREA_SPAN
                     && a[1:0] == 2'h0) begin
            cur = {16'h0000, s.out_area[{oidx, 4'h0} +: 16]};
        end else if (a >= siowa_pkg::SIOWA_IN_BASE && a <
                     siowa_pkg::SIOWA_IN_BASE + siowa_pkg::SIOWA_AREA_SPAN
                     && a[1:0] == 2'h0) begin
            cur = {16'h0000, s.in_area[{iidx, 4'h0} +: 16]};
        end else if (a >= siowa_pkg::SIOWA_CFG_BASE && a <
                     siowa_pkg::SIOWA_CFG_BASE + siowa_pkg::SIOWA_CFG_SPAN
                     && a[1:0] == 2'h0) begin
            cur = {22'h0, s.cfg[cidx]};
        end
        if (rd || wr) begin
            next_s.ack = 1'b1;
        end
        if (rd) begin
            next_s.rdata = cur;
        end
        merged = merge(cur, avm.writedata, avm.byteenable);
        // reads of unmapped or input words return cur; writes there drop
        if (wr) begin
            if (a == siowa_pkg::SIOWA_ADDR_CTRL) begin
                next_s.run = merged[siowa_pkg::SIOWA_CTRL_RUN];
                next_s.wide = merged[siowa_pkg::SIOWA_CTRL_WIDE];
                restart = merged[siowa_pkg::SIOWA_CTRL_RESTART];
            end else if (a >= siowa_pkg::SIOWA_OUT_BASE && a <
                         siowa_pkg::SIOWA_OUT_BASE +
                         siowa_pkg::SIOWA_AREA_SPAN && a[1:0] == 2'h0) begin
                next_s.out_area[{oidx, 4'h0} +: 16] = merged[15:0];
            end else if (a >= siowa_pkg::SIOWA_CFG_BASE && a <
                         siowa_pkg::SIOWA_CFG_BASE +
                         siowa_pkg::SIOWA_CFG_SPAN && a[1:0] == 2'h0) begin
                next_s.cfg[cidx] = siowa_pkg::siowa_cfg_t'(merged[9:0]);
            end
        end
        if (restart) begin
            next_s.act_out = 16'h0000;
            next_s.act_in = 16'h0000;
            next_s.err_out = 16'h0000;
            next_s.err_in = 16'h0000;
            next_s.in_area = '0;
        end
        // link events come after the clear, so a same-cycle event survives
        fire = link_req.valid & s.run;
        fc = s.cfg[link_req.entry];
        acc_fire = fire & acc[link_req.entry];
        sh = {base[link_req.entry], 3'b000};
        f_mask = dmask[link_req.entry];
        fo_slots = (acc_fire && fc.out_dir) ? slots[link_req.entry] : 16'h0;
        fi_slots = (acc_fire && fc.in_dir) ? slots[link_req.entry] : 16'h0;
        wmask = {64'h0, f_mask} << sh;
        wdat = {64'h0, link_req.in_data & f_mask} << sh;
        if (fire) begin
            next_s.rsp.valid = 1'b1;
            next_s.rsp.accepted = acc_fire;
            if (fo_slots != 16'h0) begin
                next_s.rsp.out_data = 64'(s.out_area >> sh) & f_mask;
            end
            next_s.act_out = next_s.act_out | fo_slots;
            next_s.act_in = next_s.act_in | fi_slots;
            if (link_req.ok) begin
                next_s.err_out = next_s.err_out & ~fo_slots;
                next_s.err_in = next_s.err_in & ~fi_slots;
                if (fi_slots != 16'h0) begin
                    next_s.in_area = (next_s.in_area & ~wmask) | wdat;
                end
            end else begin
                next_s.err_out = next_s.err_out | fo_slots;
                next_s.err_in = next_s.err_in | fi_slots;
            end
        end
        next_s.lamp = s.run & ~(|rej);
    end

    // ==========================================================
    // state register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.run <= siowa_pkg::SIOWA_RUN_RST;
            s.wide <= siowa_pkg::SIOWA_WIDE_RST;
        end else begin
            s <= next_s;
        end
    end

    assign avs_readdata = s.rdata;
    // one wait state on every access
    assign avs_waitrequest = (avm.read | avm.write) & ~s.ack;
    assign link_rsp = s.rsp;
    assign link_participation_lamp = s.lamp;

    // ==========================================================
    // assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_lamp_off;
        (|rej) |=> !link_participation_lamp;
    endproperty
    a_lamp_off: assert property (p_lamp_off)
        else $error("lamp on while a slave is refused");

    property p_refused_rsp;
        (fire && !acc_fire) |=> (link_rsp.valid && !link_rsp.accepted &&
                                 link_rsp.out_data == 64'h0);
    endproperty
    a_refused_rsp: assert property (p_refused_rsp)
        else $error("refused slave got data");

    property p_act_out;
        (fo_slots != 16'h0) |=> ((s.act_out & $past(fo_slots)) ==
                                 $past(fo_slots));
    endproperty
    a_act_out: assert property (p_act_out)
        else $error("output active flag not set");

    property p_act_in;
        (fi_slots != 16'h0) |=> ((s.act_in & $past(fi_slots)) ==
                                 $past(fi_slots));
    endproperty
    a_act_in: assert property (p_act_in)
        else $error("input active flag not set");

    property p_act_hold;
        !restart |=> (((s.act_out & $past(s.act_out)) == $past(s.act_out)) &&
                      ((s.act_in & $past(s.act_in)) == $past(s.act_in)));
    endproperty
    a_act_hold: assert property (p_act_hold)
        else $error("active flag dropped without restart");

    property p_restart_clr;
        (restart && !fire) |=> (s.act_out == 16'h0 && s.act_in == 16'h0 &&
                                s.err_out == 16'h0 && s.err_in == 16'h0);
    endproperty
    a_restart_clr: assert property (p_restart_clr)
        else $error("restart left flags set");

    property p_err_set;
        (fo_slots != 16'h0 && !link_req.ok) |=>
            ((s.err_out & $past(fo_slots)) == $past(fo_slots));
    endproperty
    a_err_set: assert property (p_err_set)
        else $error("error flag not set on failure");

    property p_err_clr;
        (fo_slots != 16'h0 && link_req.ok) |=>
            ((s.err_out & $past(fo_slots)) == 16'h0);
    endproperty
    a_err_clr: assert property (p_err_clr)
        else $error("error flag not cleared on good exchange");

    property p_mixed_in;
        (fo_slots != 16'h0 && fi_slots != 16'h0 && link_req.ok) |=>
            ((64'(s.in_area >> $past(sh)) & $past(f_mask)) ==
             ($past(link_req.in_data) & $past(f_mask)));
    endproperty
    a_mixed_in: assert property (p_mixed_in)
        else $error("mixed slave input not stored at its node");

    property p_nibble;
        (acc_fire && fc.size == siowa_pkg::SIOWA_P4) |=>
            (link_rsp.out_data[63:4] == 60'h0);
    endproperty
    a_nibble: assert property (p_nibble)
        else $error("4-point slave saw more than a nibble");

    property p_bus_wait;
        ((avm.read || avm.write) && avs_waitrequest) |=> !avs_waitrequest;
    endproperty
    a_bus_wait: assert property (p_bus_wait)
        else $error("bus answer later than one wait state");
endmodule

// file: siowa_pkg.sv
// constants, field layouts and carrier types of the slave i/o word allocator
package siowa_pkg;

    // ==========================================================
    // geometry
    localparam int SIOWA_SLOTS = 16;
    localparam int SIOWA_NARROW_SLOTS = 8;

    // ==========================================================
    // register byte addresses
    localparam logic [7:0] SIOWA_ADDR_CTRL = 8'h00;
    localparam logic [7:0] SIOWA_ADDR_STATUS = 8'h04;
    localparam logic [7:0] SIOWA_ADDR_ACTIVE = 8'h08;
    localparam logic [7:0] SIOWA_ADDR_ERROR = 8'h0c;
    localparam logic [7:0] SIOWA_OUT_BASE = 8'h10;
    localparam logic [7:0] SIOWA_IN_BASE = 8'h30;
    localparam logic [7:0] SIOWA_AREA_SPAN = 8'h20;
    localparam logic [7:0] SIOWA_CFG_BASE = 8'h80;
    localparam logic [7:0] SIOWA_CFG_SPAN = 8'h40;

    // ==========================================================
    // field positions and reset values
    localparam int SIOWA_CTRL_RUN = 0;
    localparam int SIOWA_CTRL_WIDE = 1;
    localparam int SIOWA_CTRL_RESTART = 2;
    localparam logic SIOWA_RUN_RST = 1'b0;
    localparam logic SIOWA_WIDE_RST = 1'b0;
    localparam logic [31:0] SIOWA_UNMAPPED_RD = 32'h0000_0000;
    localparam logic [63:0] SIOWA_NIBBLE_MASK = 64'h0000_0000_0000_000f;

    // ==========================================================
    // point counts of a slave
    typedef enum logic [2:0] {
        SIOWA_P4 = 3'h0,
        SIOWA_P8 = 3'h1,
        SIOWA_P16 = 3'h2,
        SIOWA_P32 = 3'h3,
        SIOWA_P48 = 3'h4,
        SIOWA_P64 = 3'h5
    } siowa_size_t;

    function automatic logic [3:0] siowa_slot_count(input siowa_size_t sz);
        logic [3:0] c;
        c = 4'h0;
        case (sz)
            SIOWA_P4: c = 4'h1;
            SIOWA_P8: c = 4'h1;
            SIOWA_P16: c = 4'h2;
            SIOWA_P32: c = 4'h4;
            SIOWA_P48: c = 4'h6;
            SIOWA_P64: c = 4'h8;
            default: c = 4'h0;
        endcase
        return c;
    endfunction

    // ==========================================================
    // carriers
    typedef struct packed {
        logic en;
        logic in_dir;
        logic out_dir;
        siowa_size_t size;
        logic [3:0] node;
    } siowa_cfg_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } siowa_avm_req_t;

    typedef struct packed {
        logic valid;
        logic [3:0] entry;
        logic ok;
        logic [63:0] in_data;
    } siowa_link_req_t;

    typedef struct packed {
        logic valid;
        logic accepted;
        logic [63:0] out_data;
    } siowa_link_rsp_t;

    typedef struct packed {
        logic run;
        logic wide;
        logic lamp;
        logic ack;
        logic [31:0] rdata;
        siowa_cfg_t [15:0] cfg;
        logic [127:0] out_area;
        logic [127:0] in_area;
        logic [15:0] act_out;
        logic [15:0] act_in;
        logic [15:0] err_out;
        logic [15:0] err_in;
        siowa_link_rsp_t rsp;
    } siowa_state_t;

endpackage

// file: siowa_span.sv
// slot span decoder for one configured slave
`timescale 1ns/10ps
module siowa_span #(
    parameter int NARROW_SLOTS = siowa_pkg::SIOWA_NARROW_SLOTS
) (
    input wire siowa_pkg::siowa_cfg_t cfg,
    input wire logic wide,
    output logic [3:0] base,
    output logic [15:0] slots,
    output logic [63:0] dmask,
    output logic legal
);
    logic [3:0] cnt;
    logic [4:0] last;
    logic [4:0] limit;

    always_comb begin
        cnt = siowa_pkg::siowa_slot_count(cfg.size);
        base = (cnt == 4'h1) ? cfg.node : {cfg.node[3:1], 1'b0};
        last = {1'b0, base} + {1'b0, cnt} - 5'h01;
        limit = wide ? 5'(siowa_pkg::SIOWA_SLOTS) : 5'(NARROW_SLOTS);
        legal = cfg.en & (cfg.out_dir | cfg.in_dir) & (cnt != 4'h0) &
                (last < limit);
        slots = 16'(((32'h1 << cnt) - 32'h1) << base);
        // only the low nibble is live
        if (cfg.size == siowa_pkg::SIOWA_P4) begin
            dmask = siowa_pkg::SIOWA_NIBBLE_MASK;
        end else begin
            dmask = ~(64'hffff_ffff_ffff_ffff << {cnt, 3'b000});
        end
    end
endmodule

// file: siowa_slave_model.sv
// behavioural slave terminal that sends one link exchange per request
`timescale 1ns/10ps
module siowa_slave_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic send,
    input wire logic [3:0] s_entry,
    input wire logic s_ok,
    input wire logic [63:0] s_data,
    output siowa_pkg::siowa_link_req_t link_req
);
    // ==========================================================
    // exchange driver
    // released data toggles so stale values never match by luck
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            link_req <= '0;
        end else if (send) begin
            link_req <= {1'b1, s_entry, s_ok, s_data};
        end else begin
            link_req.valid <= 1'b0;
            link_req.in_data <= ~link_req.in_data;
        end
    end
endmodule

// file: tb_top.sv
// self-checking bench of the slave i/o word allocator
`timescale 1ns/10ps
module tb_top;
    // ==========================================================
    // signals
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    siowa_pkg::siowa_avm_req_t avm = '0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    siowa_pkg::siowa_link_req_t link_req;
    siowa_pkg::siowa_link_rsp_t link_rsp;
    logic link_participation_lamp;
    logic send = 1'b0;
    logic [3:0] s_entry = 4'h0;
    logic s_ok = 1'b0;
    logic [63:0] s_data = 64'h0;
    logic [31:0] rdat;
    logic acc;
    logic got;
    logic [63:0] od;
    int fail_count = 0;
    int total_checks = 0;
    int cyc = 0;

    always #10 sys_clk = ~sys_clk;

    siowa_top DUT (
        .sys_clk(sys_clk), .rst_n(rst_n), .avm(avm),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .link_req(link_req), .link_rsp(link_rsp),
        .link_participation_lamp(link_participation_lamp)
    );

    siowa_slave_model slave (
        .sys_clk(sys_clk), .rst_n(rst_n), .send(send),
        .s_entry(s_entry), .s_ok(s_ok), .s_data(s_data),
        .link_req(link_req)
    );

    // ==========================================================
    // shared tasks
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // a hang costs a mismatch rather than a silent stall
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic ck(input string nm, input logic [63:0] s, e);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic rs;
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
    endtask

    // request held until waitrequest is sampled low at a rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        avm.write <= 1'b1;
        avm.address <= a;
        avm.writedata <= v;
        avm.byteenable <= 4'hf;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
        avm.write <= 1'b0;
    endtask

    // read data taken at the same edge that sees waitrequest low
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        avm.read <= 1'b1;
        avm.address <= a;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
        rdat = avs_readdata;
        avm.read <= 1'b0;
    endtask

    task automatic cf(input logic [3:0] e, n, input logic [2:0] s,
                      input logic o, i);
        wr(8'h80 + {2'b00, e, 2'b00}, {22'h0, 1'b1, i, o, s, n});
    endtask

    task automatic lk(input logic [3:0] e, input logic k,
                      input logic [63:0] v);
        int n;
        @(posedge sys_clk);
        send <= 1'b1;
        s_entry <= e;
        s_ok <= k;
        s_data <= v;
        @(posedge sys_clk);
        send <= 1'b0;
        got = 1'b0;
        for (n = 0; n < 8 && got == 1'b0; n++) begin
            @(negedge sys_clk);
            if (link_rsp.valid === 1'b1) begin
                got = 1'b1;
                acc = link_rsp.accepted;
                od = link_rsp.out_data;
            end
        end
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset;
        rd(8'h00); ck("ctrl", rdat, 0);
        rd(8'h08); ck("active", rdat, 0);
        rd(8'h0c); ck("error", rdat, 0);
        rd(8'h04); ck("status", rdat, 0);
        $display("test reset done");
    endtask

    // second entry lands on a claimed slot on purpose
    task automatic t_p16;
        rs(); wr(8'h00, 32'h3);
        cf(4'h0, 4'h5, 3'h2, 1'b1, 1'b0);
        cf(4'h1, 4'h4, 3'h1, 1'b1, 1'b0);
        wr(8'h18, 32'hb7a4);
        lk(4'h0, 1'b1, 64'h0);
        ck("acc0", acc, 1);
        ck("out0", od, 64'hb7a4);
        lk(4'h1, 1'b1, 64'h0);
        ck("acc1", acc, 0);
        rd(8'h08); ck("active", rdat, 32'h30);
        rd(8'h04); ck("status", rdat, 32'h0002_0000);
        wr(8'h84, 32'h0);
        rd(8'h04); ck("lamp", rdat, 32'h1);
        $display("test p16 done");
    endtask

    task automatic t_mix8;
        rs(); wr(8'h00, 32'h3);
        cf(4'h0, 4'h2, 3'h1, 1'b1, 1'b1);
        cf(4'h1, 4'h3, 3'h1, 1'b1, 1'b0);
        cf(4'h2, 4'h3, 3'h1, 1'b0, 1'b1);
        wr(8'h14, 32'h00c3);
        lk(4'h0, 1'b1, 64'h5e);
        ck("out", od, 64'hc3);
        rd(8'h08); ck("active", rdat, 32'h0004_0004);
        rd(8'h0c); ck("err", rdat, 0);
        rd(8'h34); ck("in", rdat, 32'h5e);
        rd(8'h04); ck("status", rdat, 32'h1);
        $display("test mix8 done");
    endtask

    // third entry lands on claimed slot 7 on purpose and is refused
    task automatic t_p4;
        rs(); wr(8'h00, 32'h3);
        cf(4'h0, 4'h7, 3'h0, 1'b1, 1'b1);
        cf(4'h1, 4'h6, 3'h0, 1'b1, 1'b0);
        cf(4'h2, 4'h7, 3'h0, 1'b1, 1'b0);
        wr(8'h1c, 32'hffff);
        lk(4'h0, 1'b1, 64'hff);
        ck("out7", od, 64'h0f);
        rd(8'h3c); ck("in7", rdat, 32'h0f00);
        lk(4'h1, 1'b1, 64'h0);
        ck("out6", od, 64'h0f);
        rd(8'h04); ck("status", rdat, 32'h0004_0000);
        $display("test p4 done");
    endtask

    task automatic t_p32;
        rs(); wr(8'h00, 32'h3);
        cf(4'h0, 4'h1, 3'h3, 1'b0, 1'b1);
        cf(4'h1, 4'h5, 3'h2, 1'b1, 1'b1);
        wr(8'h18, 32'h9a87);
        lk(4'h0, 1'b1, 64'h4433_2211);
        rd(8'h30); ck("in0", rdat, 32'h2211);
        rd(8'h34); ck("in1", rdat, 32'h4433);
        lk(4'h1, 1'b1, 64'h6655);
        ck("out2", od, 64'h9a87);
        rd(8'h38); ck("in2", rdat, 32'h6655);
        rd(8'h08); ck("active", rdat, 32'h003f_0030);
        $display("test p32 done");
    endtask

    // narrow area of eight slots: spans past slot 7 are refused
    // last entry carries an illegal size code
    task automatic t_ana;
        logic [2:0] sz[8] = '{3'h5, 3'h4, 3'h4, 3'h3, 3'h3, 3'h2, 3'h5,
                              3'h6};
        logic [3:0] nd[8] = '{4'h1, 4'h3, 4'h4, 4'h6, 4'h5, 4'h7, 4'h2,
                              4'h0};
        logic [7:0] mk[8] = '{8'hff, 8'hfc, 8'h0, 8'h0, 8'hf0, 8'hc0, 8'h0,
                              8'h0};
        logic a;
        rs();
        for (int i = 0; i < 8; i++) begin
            cf(4'h0, nd[i], sz[i], 1'b0, 1'b1);
            wr(8'h00, 32'h5);
            lk(4'h0, 1'b1, 64'h0);
            a = (mk[i] != 8'h0);
            ck("acc", acc, a);
            ck("lamp", link_participation_lamp, a);
            rd(8'h08); ck("active", rdat, {8'h0, mk[i], 16'h0});
        end
        $display("test analog done");
    endtask

    task automatic t_flag;
        rs(); wr(8'h00, 32'h3);
        cf(4'h0, 4'h9, 3'h1, 1'b1, 1'b0);
        lk(4'h0, 1'b1, 64'h0);
        rd(8'h0c); ck("err", rdat, 0);
        lk(4'h0, 1'b0, 64'h0);
        rd(8'h08); ck("active", rdat, 32'h200);
        rd(8'h0c); ck("err", rdat, 32'h200);
        lk(4'h0, 1'b1, 64'h0);
        rd(8'h0c); ck("err", rdat, 0);
        wr(8'h00, 32'h7);
        rd(8'h08); ck("active", rdat, 0);
        wr(8'h00, 32'h2);
        lk(4'h0, 1'b1, 64'h0);
        ck("idle", got, 0);
        $display("test flags done");
    endtask

    // ==========================================================
    // main sequence
    initial begin
        rs();
        t_reset();
        t_p16();
        t_mix8();
        t_p4();
        t_p32();
        t_ana();
        t_flag();
        print_verdict();
    end
endmodule
